/* hw/trap_unit_defs.vh */
`ifndef TRAP_UNIT_DEFS_VH
`define TRAP_UNIT_DEFS_VH

// Register byte addresses on APB
`define REG_NORMAL_CAUSE   12'h000
`define REG_DEBUG_CAUSE    12'h004
`define REG_ONEHOT_CAUSE   12'h008
`define REG_FAULT_ADDR     12'h00C
`define REG_HALT_ADDR      12'h010
`define REG_TLB_DETAIL     12'h014
`define REG_RESUME_ADDR    12'h018
`define REG_RESUME_STATE   12'h01C
`define REG_RESUME2_ADDR   12'h020
`define REG_RESUME2_STATE  12'h024
`define REG_VEC_TLB        12'h028
`define REG_VEC_BREAK      12'h02C
`define REG_VEC_EXCEPT     12'h030
`define REG_VEC_INTR       12'h034
`define REG_SYNC_OPTION    12'h038

// Reset values and the debug handler address
`define RST_CAUSE          32'h0000_0000
`define RST_WORD           32'h0000_0000
`define DEBUG_HANDLER_ADDR 32'h0000_0000

// State word bit positions
`define PSW_USER_MODE      0
`define PSW_INT_ENABLE     1
`define PSW_LOCAL_RAM_ONLY 2
`define PSW_FETCH_WATCH    3
`define PSW_DATA_WATCH     4
`define PSW_TRANSLATION    5
`define PSW_DEBUG_MODE     6

// Normal cause numbers
`define NC_FILL_BUS        5'h00
`define NC_DATA_BUS        5'h01
`define NC_INTERRUPT       5'h02
`define NC_FETCH_WATCH     5'h03
`define NC_FETCH_XLATE     5'h04
`define NC_SOFT_WATCH      5'h05
`define NC_ILLEGAL         5'h06
`define NC_OS_CALL         5'h07
`define NC_DATA_WATCH      5'h08
`define NC_UNALIGNED       5'h09
`define NC_UNMAPPED_CTRL   5'h0A
`define NC_CTRL_DENIED     5'h0B
`define NC_DATA_XLATE      5'h0C
`define NC_LOCAL_RAM       5'h0D
`define NC_PORT_TIMEOUT    5'h0E

// Debug cause numbers
`define DC_HOST_EVENT      3'h0
`define DC_WRITTEN         3'h1
`define DC_TRIGGER         3'h2
`define DC_FETCH_WATCH     3'h3
`define DC_SOFT_WATCH      3'h4
`define DC_DATA_WATCH      3'h5

// Trap request vector width, index 0 is highest priority
`define TRAP_COUNT         22

`endif

/* hw/trap_entry_return_unit.v */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "trap_unit_defs.vh"

module trap_entry_return_unit (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Trap requests from the pipeline, one bundle per cycle
    input  wire        bundle_valid,
    input  wire [31:0] trapping_bundle_addr,
    input  wire [31:0] fault_vaddr,
    input  wire [31:0] syllable_vaddr,
    input  wire [31:0] tlb_detail_in,
    input  wire        host_event,
    input  wire        written_halt_request,
    input  wire        trigger_in,
    input  wire        fill_bus_fault,
    input  wire        store_bus_fault,
    input  wire        interrupt_req,
    input  wire        halt_fetch_watch_hit,
    input  wire        fetch_watch_hit,
    input  wire        fetch_translation_fault,
    input  wire        halt_soft_watch_hit,
    input  wire        soft_watch_hit,
    input  wire        illegal_bundle,
    input  wire        os_call_request,
    input  wire        halt_data_watch_hit,
    input  wire        data_watch_hit,
    input  wire        unaligned_access,
    input  wire        unmapped_control_access,
    input  wire        control_access_denied,
    input  wire        data_translation_fault,
    input  wire        local_ram_rule_breach,
    input  wire        sideband_port_timeout,
    input  wire        load_bus_fault,
    input  wire        sync_bus_fault,
    // Return from trap and state word write from the pipeline
    input  wire        return_req,
    input  wire        psw_write,
    input  wire [31:0] psw_wdata,
    // Outputs to the pipeline, and the reservation_set input from it
    output reg         redirect,
    output reg  [31:0] redirect_addr,
    output reg  [31:0] processor_state_word,
    output reg         reservation_held,
    output reg         reservation_shadow_held,
    output reg         load_issue_ok,
    input  wire        reservation_set
);

    // Stored state
    reg  [4:0]  normal_trap_cause_number;
    reg  [2:0]  debug_trap_cause_number;
    reg  [31:0] fault_address_reg;
    reg  [31:0] halt_fault_address_reg;
    reg  [31:0] translation_fault_detail;
    reg  [31:0] resume_addr_copy;
    reg  [31:0] resume_state_copy;
    reg  [31:0] second_resume_addr_copy;
    reg  [31:0] second_resume_state_copy;
    reg  [31:0] vec_tlb;
    reg  [31:0] vec_break;
    reg  [31:0] vec_except;
    reg  [31:0] vec_intr;
    reg         sync_async_option;
    reg         store_fault_pend;

    // Trap selection
    wire [`TRAP_COUNT-1:0] req;
    reg  [`TRAP_COUNT-1:0] is_debug;
    reg  [4:0]  req_code [0:`TRAP_COUNT-1];
    reg  [4:0]  win_idx;
    reg         win_any;
    reg  [4:0]  win_code;
    reg         win_debug;
    reg  [31:0] win_vector;
    reg  [31:0] next_fault_addr;
    reg  [31:0] next_detail;
    reg  [31:0] next_halt_addr;
    wire        other_trap;
    wire        sync_fault_low;
    wire [31:0] onehot_cause_view;
    integer     i;

    wire        apb_wr = psel & penable & pwrite & pready;
    wire        apb_rd = psel & ~penable & ~pwrite;

    assign other_trap     = |req[`TRAP_COUNT-2:0];
    assign sync_fault_low = sync_bus_fault & ~sync_async_option;
    assign onehot_cause_view = 32'h0000_0001 << normal_trap_cause_number;

    // Priority order: index 0 is priority 1
    assign req[0]  = host_event;
    assign req[1]  = written_halt_request;
    assign req[2]  = trigger_in;
    assign req[3]  = bundle_valid & fill_bus_fault;
    assign req[4]  = store_fault_pend | (sync_bus_fault & sync_async_option);
    assign req[5]  = interrupt_req;
    assign req[6]  = bundle_valid & halt_fetch_watch_hit;
    assign req[7]  = bundle_valid & fetch_watch_hit;
    assign req[8]  = bundle_valid & fetch_translation_fault;
    assign req[9]  = bundle_valid & halt_soft_watch_hit;
    assign req[10] = bundle_valid & soft_watch_hit;
    assign req[11] = bundle_valid & illegal_bundle;
    assign req[12] = bundle_valid & os_call_request;
    assign req[13] = bundle_valid & halt_data_watch_hit;
    assign req[14] = bundle_valid & data_watch_hit;
    assign req[15] = bundle_valid & unaligned_access;
    assign req[16] = bundle_valid & unmapped_control_access;
    assign req[17] = bundle_valid & control_access_denied;
    assign req[18] = bundle_valid & data_translation_fault;
    assign req[19] = bundle_valid & local_ram_rule_breach;
    assign req[20] = bundle_valid & sideband_port_timeout;
    assign req[21] = bundle_valid & (load_bus_fault | sync_fault_low);

    // Highest priority wins; lower ones in the bundle are dropped
    always @* begin
        // Fixed per-slot tables, rebuilt on every pass so they never stay unknown
        is_debug = 22'b00_0000_0010_0010_0100_0111;
        req_code[0]  = {2'b00, `DC_HOST_EVENT};
        req_code[1]  = {2'b00, `DC_WRITTEN};
        req_code[2]  = {2'b00, `DC_TRIGGER};
        req_code[3]  = `NC_FILL_BUS;
        req_code[4]  = `NC_DATA_BUS;
        req_code[5]  = `NC_INTERRUPT;
        req_code[6]  = {2'b00, `DC_FETCH_WATCH};
        req_code[7]  = `NC_FETCH_WATCH;
        req_code[8]  = `NC_FETCH_XLATE;
        req_code[9]  = {2'b00, `DC_SOFT_WATCH};
        req_code[10] = `NC_SOFT_WATCH;
        req_code[11] = `NC_ILLEGAL;
        req_code[12] = `NC_OS_CALL;
        req_code[13] = {2'b00, `DC_DATA_WATCH};
        req_code[14] = `NC_DATA_WATCH;
        req_code[15] = `NC_UNALIGNED;
        req_code[16] = `NC_UNMAPPED_CTRL;
        req_code[17] = `NC_CTRL_DENIED;
        req_code[18] = `NC_DATA_XLATE;
        req_code[19] = `NC_LOCAL_RAM;
        req_code[20] = `NC_PORT_TIMEOUT;
        req_code[21] = `NC_DATA_BUS;

        // Lowest requesting slot wins
        win_any = 1'b0;
        win_idx = 5'd0;
        for (i = `TRAP_COUNT-1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                win_any = 1'b1;
                win_idx = i[4:0];
            end
        end
        win_code  = req_code[win_idx];
        win_debug = is_debug[win_idx];
    end

    // Handler selection per trap class
    always @* begin
        case (win_code)
            `NC_FETCH_XLATE, `NC_DATA_XLATE: win_vector = vec_tlb;
            `NC_FETCH_WATCH, `NC_SOFT_WATCH, `NC_DATA_WATCH: win_vector = vec_break;
            `NC_INTERRUPT: win_vector = vec_intr;
            default: win_vector = vec_except;
        endcase
        if (win_debug) begin
            win_vector = `DEBUG_HANDLER_ADDR;
        end
    end

    // Fault address and detail for the winner
    always @* begin
        next_fault_addr = 32'h0000_0000;
        next_detail     = 32'h0000_0000;
        next_halt_addr  = 32'h0000_0000;
        case (win_code)
            `NC_DATA_WATCH, `NC_UNALIGNED, `NC_UNMAPPED_CTRL,
            `NC_CTRL_DENIED, `NC_DATA_XLATE: next_fault_addr = fault_vaddr;
            `NC_FETCH_XLATE: next_fault_addr = syllable_vaddr;
            default: next_fault_addr = 32'h0000_0000;
        endcase
        if (win_code == `NC_FETCH_XLATE || win_code == `NC_DATA_XLATE) begin
            next_detail = tlb_detail_in;
        end
        if (win_code == {2'b00, `DC_DATA_WATCH}) begin
            next_halt_addr = fault_vaddr;
        end
    end

    // Trap entry and return, each in one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_trap_cause_number <= 5'h00;
            debug_trap_cause_number  <= 3'h0;
            fault_address_reg        <= `RST_WORD;
            halt_fault_address_reg   <= `RST_WORD;
            translation_fault_detail <= `RST_WORD;
            resume_addr_copy         <= `RST_WORD;
            resume_state_copy        <= `RST_WORD;
            second_resume_addr_copy  <= `RST_WORD;
            second_resume_state_copy <= `RST_WORD;
            processor_state_word     <= `RST_WORD;
            reservation_held         <= 1'b0;
            reservation_shadow_held  <= 1'b0;
            redirect                 <= 1'b0;
            redirect_addr            <= `RST_WORD;
            store_fault_pend         <= 1'b0;
            load_issue_ok            <= 1'b0;
        end else begin
            redirect <= 1'b0;
            load_issue_ok <= ~other_trap;
            // Store fault pends until taken; new fault wins over the take
            if (store_bus_fault) begin
                store_fault_pend <= 1'b1;
            end else if (win_any && win_idx == 5'd4) begin
                store_fault_pend <= 1'b0;
            end
            if (reservation_set) begin
                reservation_held <= 1'b1;
                reservation_shadow_held <= 1'b1;
            end
            if (psw_write) begin
                processor_state_word <= psw_wdata;
            end
            if (apb_wr) begin
                case (paddr)
                    `REG_NORMAL_CAUSE:  normal_trap_cause_number <= pwdata[4:0];
                    `REG_DEBUG_CAUSE:   debug_trap_cause_number <= pwdata[2:0];
                    `REG_FAULT_ADDR:    fault_address_reg <= pwdata;
                    `REG_HALT_ADDR:     halt_fault_address_reg <= pwdata;
                    `REG_TLB_DETAIL:    translation_fault_detail <= pwdata;
                    `REG_RESUME_ADDR:   resume_addr_copy <= pwdata;
                    `REG_RESUME_STATE:  resume_state_copy <= pwdata;
                    `REG_RESUME2_ADDR:  second_resume_addr_copy <= pwdata;
                    `REG_RESUME2_STATE: second_resume_state_copy <= pwdata;
                    default: ;
                endcase
            end
            if (win_any && !win_debug) begin
                redirect <= 1'b1;
                redirect_addr <= win_vector;
                normal_trap_cause_number <= win_code;
                fault_address_reg <= next_fault_addr;
                translation_fault_detail <= next_detail;
                resume_state_copy <= processor_state_word;
                resume_addr_copy <= trapping_bundle_addr;
                reservation_held <= 1'b0;
                processor_state_word[`PSW_USER_MODE]      <= 1'b0;
                processor_state_word[`PSW_INT_ENABLE]     <= 1'b0;
                processor_state_word[`PSW_LOCAL_RAM_ONLY] <= 1'b0;
                processor_state_word[`PSW_FETCH_WATCH]    <= 1'b0;
                processor_state_word[`PSW_DATA_WATCH]     <= 1'b0;
            end else if (win_any && win_debug) begin
                redirect <= 1'b1;
                redirect_addr <= win_vector;
                debug_trap_cause_number <= win_code[2:0];
                halt_fault_address_reg <= next_halt_addr;
                resume_state_copy <= processor_state_word;
                resume_addr_copy <= trapping_bundle_addr;
                second_resume_addr_copy <= resume_addr_copy;
                second_resume_state_copy <= resume_state_copy;
                reservation_held <= 1'b0;
                processor_state_word[`PSW_USER_MODE]      <= 1'b0;
                processor_state_word[`PSW_DEBUG_MODE]     <= 1'b1;
                processor_state_word[`PSW_INT_ENABLE]     <= 1'b0;
                processor_state_word[`PSW_LOCAL_RAM_ONLY] <= 1'b0;
                processor_state_word[`PSW_FETCH_WATCH]    <= 1'b0;
                processor_state_word[`PSW_DATA_WATCH]     <= 1'b0;
                processor_state_word[`PSW_TRANSLATION]    <= 1'b0;
            end else if (return_req) begin
                redirect <= 1'b1;
                redirect_addr <= resume_addr_copy;
                processor_state_word <= resume_state_copy;
                resume_addr_copy <= second_resume_addr_copy;
                resume_state_copy <= second_resume_state_copy;
                reservation_held <= 1'b0;
                reservation_shadow_held <= 1'b0;
            end
        end
    end

    // Handler vectors and option
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_tlb <= `RST_WORD;
            vec_break <= `RST_WORD;
            vec_except <= `RST_WORD;
            vec_intr <= `RST_WORD;
            sync_async_option <= 1'b0;
        end else if (apb_wr) begin
            case (paddr)
                `REG_VEC_TLB:     vec_tlb <= pwdata;
                `REG_VEC_BREAK:   vec_break <= pwdata;
                `REG_VEC_EXCEPT:  vec_except <= pwdata;
                `REG_VEC_INTR:    vec_intr <= pwdata;
                `REG_SYNC_OPTION: sync_async_option <= pwdata[0];
                default: ;
            endcase
        end
    end

    // APB: no wait states, data latched in setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                pslverr <= (paddr > `REG_SYNC_OPTION) | (paddr[1:0] != 2'b00) |
                           (pwrite & (paddr == `REG_ONEHOT_CAUSE));
            end
            if (apb_rd) begin
                case (paddr)
                    `REG_NORMAL_CAUSE:  prdata <= {27'h0, normal_trap_cause_number};
                    `REG_DEBUG_CAUSE:   prdata <= {29'h0, debug_trap_cause_number};
                    `REG_ONEHOT_CAUSE:  prdata <= onehot_cause_view;
                    `REG_FAULT_ADDR:    prdata <= fault_address_reg;
                    `REG_HALT_ADDR:     prdata <= halt_fault_address_reg;
                    `REG_TLB_DETAIL:    prdata <= translation_fault_detail;
                    `REG_RESUME_ADDR:   prdata <= resume_addr_copy;
                    `REG_RESUME_STATE:  prdata <= resume_state_copy;
                    `REG_RESUME2_ADDR:  prdata <= second_resume_addr_copy;
                    `REG_RESUME2_STATE: prdata <= second_resume_state_copy;
                    `REG_VEC_TLB:       prdata <= vec_tlb;
                    `REG_VEC_BREAK:     prdata <= vec_break;
                    `REG_VEC_EXCEPT:    prdata <= vec_except;
                    `REG_VEC_INTR:      prdata <= vec_intr;
                    `REG_SYNC_OPTION:   prdata <= {31'h0, sync_async_option};
                    default:            prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // trap_entry_return_unit

/* verification/trap_entry_return_unit_props.sv */
`timescale 1ns/1ps
`include "trap_unit_defs.vh"

module trap_unit_checker (
    // Clock, reset and APB
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // Trap requests and pipeline controls
    input wire logic        bundle_valid, illegal_bundle, host_event, written_halt_request,
    input wire logic        trigger_in, interrupt_req, return_req, psw_write, reservation_set,
    // Pipeline outputs
    input wire logic        redirect, reservation_held, load_issue_ok,
    input wire logic [31:0] redirect_addr, processor_state_word
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire no_debug = !host_event && !written_halt_request && !trigger_in;
    wire rd_done  = psel && penable && pready && !pwrite;
    wire bad_bndl = bundle_valid && illegal_bundle;

    sequence halt_req;
        host_event && !psw_write && !processor_state_word[6];
    endsequence

    trap_redirect_a: assert property (bad_bndl |=> redirect)
        else $error("bundle trap gave no redirect");
    normal_state_a: assert property (bad_bndl && no_debug && !psw_write |=>
        processor_state_word[4:0] == 5'h00) else $error("state bits not cleared on trap");
    normal_lock_a: assert property (bad_bndl && !reservation_set |=> !reservation_held)
        else $error("reservation kept over trap");
    debug_entry_a: assert property (halt_req |=> redirect &&
        redirect_addr == `DEBUG_HANDLER_ADDR) else $error("halt request missed handler");
    debug_state_a: assert property (halt_req |=> processor_state_word[6:0] == 7'h40)
        else $error("halt entry state word wrong");
    return_lock_a: assert property (return_req && !bundle_valid && no_debug && !interrupt_req
        && !reservation_set |=> redirect && !reservation_held) else $error("return wrong");
    cause_upper_a: assert property (rd_done && paddr == `REG_NORMAL_CAUSE |->
        prdata[31:5] == 27'h0) else $error("cause upper bits set");
    debug_upper_a: assert property (rd_done && paddr == `REG_DEBUG_CAUSE |->
        prdata[31:3] == 29'h0) else $error("halt cause upper bits set");
    onehot_view_a: assert property (rd_done && paddr == `REG_ONEHOT_CAUSE |->
        $onehot(prdata)) else $error("onehot view not one hot");
    load_block_a: assert property (bad_bndl |=> !load_issue_ok)
        else $error("load allowed after trapping bundle");

    cover property (host_event ##1 redirect);
    cover property (return_req ##1 redirect);
    cover property (rd_done && pslverr);
endmodule // trap_unit_checker

bind trap_entry_return_unit trap_unit_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
    .bundle_valid(bundle_valid), .illegal_bundle(illegal_bundle), .host_event(host_event),
    .written_halt_request(written_halt_request), .trigger_in(trigger_in),
    .interrupt_req(interrupt_req), .return_req(return_req), .psw_write(psw_write),
    .reservation_set(reservation_set), .redirect(redirect), .reservation_held(reservation_held),
    .load_issue_ok(load_issue_ok), .redirect_addr(redirect_addr),
    .processor_state_word(processor_state_word)
);

/* verification/test_trap_entry_return_unit.sv */
`timescale 1ns/1ps
`include "trap_unit_defs.vh"

module test_trap_entry_return_unit;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, redirect_addr, state_word, psw_wdata;
    logic        bundle_valid, return_req, psw_write, reservation_set, redirect, held, shadow;
    logic        lok, opt;
    logic [22:0] rq;
    logic [31:0] ba, fv, sv, tv, pw, ps, nc, dc, fa, ha, td, ra, rs, ra2, rs2;
    logic [31:0] vec [4];
    int          n_errors, n_compared, cyc;

    trap_entry_return_unit DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bundle_valid(bundle_valid), .trapping_bundle_addr(ba), .fault_vaddr(fv),
        .syllable_vaddr(sv), .tlb_detail_in(tv), .host_event(rq[15]),
        .written_halt_request(rq[16]), .trigger_in(rq[17]), .fill_bus_fault(rq[0]),
        .store_bus_fault(rq[22]), .interrupt_req(rq[2]), .halt_fetch_watch_hit(rq[18]),
        .fetch_watch_hit(rq[3]), .fetch_translation_fault(rq[4]), .halt_soft_watch_hit(rq[19]),
        .soft_watch_hit(rq[5]), .illegal_bundle(rq[6]), .os_call_request(rq[7]),
        .halt_data_watch_hit(rq[20]), .data_watch_hit(rq[8]), .unaligned_access(rq[9]),
        .unmapped_control_access(rq[10]), .control_access_denied(rq[11]),
        .data_translation_fault(rq[12]), .local_ram_rule_breach(rq[13]),
        .sideband_port_timeout(rq[14]), .load_bus_fault(rq[1]), .sync_bus_fault(rq[21]),
        .return_req(return_req), .psw_write(psw_write), .psw_wdata(psw_wdata),
        .redirect(redirect), .redirect_addr(redirect_addr), .processor_state_word(state_word),
        .reservation_held(held), .reservation_shadow_held(shadow), .load_issue_ok(lok),
        .reservation_set(reservation_set)
    );

    always #10 pclk = ~pclk;

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; returns one idle edge after the completing edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic regs();
        logic [31:0] e [10];
        logic [31:0] r;
        logic        er;
        e = '{nc, dc, 32'h1 << nc, fa, ha, td, ra, rs, ra2, rs2};
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000, r, er);
            chk(r, e[i]);
            chk(er, 0);
        end
    endtask

    // Request bit positions in trap priority order
    function automatic int win(input logic [22:0] m);
        int ord [23] = '{15, 16, 17, 0, 22, 2, 18, 3, 4, 19, 5, 6, 7, 20, 8, 9, 10, 11, 12,
                         13, 14, 1, 21};
        for (int i = 0; i < 23; i++)
            if (m[ord[i]] || (ord[i] == 22 && opt && m[21])) return ord[i];
        return -1;
    endfunction

    function automatic int cls(input int c);
        if (c == 4 || c == 12) return 0;
        if (c == 3 || c == 5 || c == 8) return 1;
        if (c == 2) return 3;
        return 2;
    endfunction

    task automatic fire(input logic [22:0] m);
        int b;
        int c;
        b = win(m);
        pw = ($urandom & 32'h0000_003F) | 32'h0000_0002;
        psw_write <= 1'b1;
        psw_wdata <= pw;
        reservation_set <= 1'b1;
        @(posedge pclk);
        psw_write <= 1'b0;
        reservation_set <= 1'b0;
        rq <= m;
        bundle_valid <= 1'b1;
        ba <= $urandom;
        fv <= $urandom;
        sv <= $urandom;
        tv <= $urandom;
        @(posedge pclk);
        rq <= '0;
        bundle_valid <= 1'b0;
        #1;
        chk(redirect, 1);
        chk(held, 0);
        chk(shadow, 1);
        chk(lok, (m & (opt ? ~23'h00_0002 : ~23'h20_0002)) == 23'h0);
        if (b >= 15 && b <= 20) begin
            dc = b - 15;
            ha = (dc == 5) ? fv : 32'h0000_0000;
            ra2 = ra;
            rs2 = rs;
            chk(redirect_addr, `DEBUG_HANDLER_ADDR);
            chk(state_word, pw & 32'hFFFF_FFC0 | 32'h0000_0040);
        end else begin
            c = (b < 15) ? b : 1;
            nc = c;
            fa = (c >= 8 && c <= 12) ? fv : (c == 4) ? sv : 32'h0000_0000;
            td = (c == 4 || c == 12) ? tv : 32'h0000_0000;
            chk(redirect_addr, vec[cls(c)]);
            chk(state_word, pw & 32'hFFFF_FFE0);
        end
        ra = ba;
        rs = pw;
        @(posedge pclk);
    endtask

    task automatic ret();
        return_req <= 1'b1;
        @(posedge pclk);
        return_req <= 1'b0;
        #1;
        chk(redirect_addr, ra);
        chk(state_word, rs);
        chk({held, shadow}, 0);
        ps = rs;
        ra = ra2;
        rs = rs2;
        @(posedge pclk);
    endtask

    initial begin
        int          n;
        logic [31:0] r;
        logic        er;
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata, psw_wdata} = '0;
        {bundle_valid, return_req, psw_write, reservation_set, rq, opt} = '0;
        {ba, fv, sv, tv, ps, nc, dc, fa, ha, td, ra, rs, ra2, rs2} = '0;
        void'($urandom(56));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs();
        for (int k = 0; k < 4; k++) begin
            vec[k] = $urandom;
            apb(1'b1, 12'h028 + 12'(4 * k), vec[k], r, er);
        end
        apb(1'b1, `REG_SYNC_OPTION, 32'h0000_0000, r, er);
        apb(1'b0, 12'h03C, 32'h0000_0000, r, er);
        chk(er, 1);
        apb(1'b1, `REG_ONEHOT_CAUSE, 32'h0000_0005, r, er);
        chk(er, 1);
        apb(1'b1, `REG_NORMAL_CAUSE, 32'hFFFF_FFFF, r, er);
        apb(1'b1, `REG_DEBUG_CAUSE, 32'hFFFF_FFFF, r, er);
        nc = 32'h0000_001F;
        dc = 32'h0000_0007;
        regs();
        for (int i = 0; i < 22; i++) begin
            fire(23'h1 << i);
            regs();
            ret();
        end
        fire(23'h00_4002);
        ra = $urandom;
        rs = $urandom;
        apb(1'b1, `REG_RESUME_ADDR, ra, r, er);
        apb(1'b1, `REG_RESUME_STATE, rs, r, er);
        ret();
        opt = 1'b1;
        apb(1'b1, `REG_SYNC_OPTION, 32'h0000_0001, r, er);
        fire(23'h20_0040);
        regs();
        ret();
        opt = 1'b0;
        apb(1'b1, `REG_SYNC_OPTION, 32'h0000_0000, r, er);
        rq[22] <= 1'b1;
        @(posedge pclk);
        rq <= '0;
        n = 0;
        while (redirect !== 1'b1 && n < 8) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(redirect, 1);
        chk(redirect_addr, vec[2]);
        nc = 1;
        fa = 0;
        td = 0;
        ra = ba;
        rs = ps;
        ret();
        regs();
        repeat (30) begin
            fire((23'h1 << ($urandom % 22)) | (23'h1 << ($urandom % 22)));
            if ($urandom % 2) begin
                fire(23'h1 << (15 + $urandom % 6));
                regs();
                ret();
            end
            regs();
            ret();
        end
        print_verdict();
    end
endmodule // test_trap_entry_return_unit
